/* File: core/s3g_pkg.sv */
// Shared constants and types for the G1 remote defect and remote error insertion logic.
package s3g_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [15:0] RX_CTRL_ADDR = 16'h1183;
    localparam logic [15:0] TX_CTRL_ADDR = 16'h1983;
    localparam logic [15:0] G1_VAL_ADDR = 16'h199f;

    // ------------------------------------------------------------
    // Field positions, reset values and writable bit masks
    // ------------------------------------------------------------
    localparam int B3_TYPE_BIT = 0;
    localparam int RDI_SRC_LSB = 3;
    localparam int REI_SRC_LSB = 5;
    localparam int G1_RDI_LSB = 1;
    localparam int G1_REI_LSB = 4;
    localparam logic [7:0] RX_CTRL_RST = 8'h00;
    localparam logic [7:0] TX_CTRL_RST = 8'h00;
    localparam logic [7:0] G1_VAL_RST = 8'h00;
    localparam logic [7:0] RX_CTRL_WMASK = 8'h0f;
    localparam logic [7:0] TX_CTRL_WMASK = 8'hfd;
    localparam logic [3:0] REI_MAX = 4'h8;

    // ------------------------------------------------------------
    // Source selection codes; SRC_AUTO and SRC_SOFT serve both fields, SRC_PORT only the RDI field
    // ------------------------------------------------------------
    localparam logic [1:0] SRC_AUTO = 2'h0;
    localparam logic [1:0] SRC_SOFT = 2'h1;
    localparam logic [1:0] SRC_PORT = 2'h2;

    // ------------------------------------------------------------
    // Serial overhead port timing, in overhead clock periods; OVH_HALF_CYCLES counts system clocks
    // ------------------------------------------------------------
    localparam int OVH_WAIT_PERIODS = 25;
    localparam int RDI_BIT_COUNT = 3;
    localparam int FIRST_LATCH = OVH_WAIT_PERIODS + 1;
    localparam int LAST_LATCH = FIRST_LATCH + RDI_BIT_COUNT - 1;
    localparam int POH_WINDOW_PERIODS = 72;
    localparam int OVH_HALF_CYCLES = 8;

    // ------------------------------------------------------------
    // State encodings
    // ------------------------------------------------------------
    typedef enum logic [0:0] {DS_IDLE = 1'b0, DS_WINDOW = 1'b1} s3g_dev_state_type;
    typedef enum logic [1:0] {
        HS_SAMPLE = 2'b00,
        HS_WAIT = 2'b01,
        HS_SHIFT = 2'b10
    } s3g_host_state_type;
endpackage : s3g_pkg

/* File: core/s3g_ovh_if.sv */
// Serial overhead port joining the framer end and the external inserter end.
`timescale 1ns/10ps
interface s3g_ovh_if;
    logic overhead_serial_clock;
    logic overhead_window_valid;
    logic overhead_frame_mark;
    logic overhead_serial_in;
    logic overhead_insert_request;

    // Framer end drives the clock and the window marks.
    modport dev (
        output overhead_serial_clock,
        output overhead_window_valid,
        output overhead_frame_mark,
        input overhead_serial_in,
        input overhead_insert_request
    );

    // External inserter end drives the serial data.
    modport host (
        input overhead_serial_clock,
        input overhead_window_valid,
        input overhead_frame_mark,
        output overhead_serial_in,
        output overhead_insert_request
    );
endinterface : s3g_ovh_if

/* File: core/s3g_dev_end.sv */
// Framer end: G1 remote defect and remote error field insertion with serial overhead port.
//
// Function
// - RDI source 01 copies value bits 3:1.
// - Zero code means no defect, nonzero defect.
// - RDI source 10 takes bits from serial pin.
// - Framer drives clock, window and frame marks.
// - Inserter waits 25 periods after both marks.
// - Latch serial bit on following rising edge.
// - Remaining two bits on next two rising edges.
// - Slot timing reflects G1 fourth byte, second bit.
// - Inserter repeats sequence every frame.
// - Insert request unneeded in port mode.
// - REI source 00 sets REI automatically.
// - Error type 0 sends B3 bit error count.
// - Error type 1 sends one-bit errored flag.
`timescale 1ns/10ps
module s3g_dev_end #(
    parameter int OVH_HALF = s3g_pkg::OVH_HALF_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    s3g_ovh_if.dev ovh,
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic spe_start,
    input wire logic g1_spare,
    input wire logic b3_update,
    input wire logic [3:0] b3_err_count,
    input wire logic b3_err_seen,
    output logic [7:0] g1_byte,
    output logic g1_valid
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [7:0] rx_ctrl_r, rx_ctrl_nxt;
    logic [7:0] tx_ctrl_r, tx_ctrl_nxt;
    logic [7:0] g1_val_r, g1_val_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic [3:0] rei_auto_r, rei_auto_nxt;
    logic [7:0] g1_byte_r, g1_byte_nxt;
    logic g1_valid_r, g1_valid_nxt;
    logic [7:0] div_r, div_nxt;
    logic ovh_clk_r, ovh_clk_nxt;
    logic rise_now, fall_now;
    logic sin_s1_r, sin_s2_r;
    s3g_pkg::s3g_dev_state_type st_r, st_nxt;
    logic pend_r, pend_nxt;
    logic frame_r, frame_nxt;
    logic valid_r, valid_nxt;
    logic [7:0] slot_r, slot_nxt;
    logic [2:0] shift_r, shift_nxt;
    logic [2:0] port_rdi_r, port_rdi_nxt;
    logic [1:0] rdi_src, rei_src;
    logic [2:0] rdi_out;
    logic [3:0] rei_out;

    // Maps a register address to a one-hot select: rx, tx, g1 value.
    function automatic logic [2:0] reg_sel(input logic [15:0] addr);
        reg_sel = {addr == s3g_pkg::G1_VAL_ADDR, addr == s3g_pkg::TX_CTRL_ADDR,
                   addr == s3g_pkg::RX_CTRL_ADDR};
    endfunction : reg_sel

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    // Writes honour the writable masks so read-only bits stay zero; reads are registered.
    always_comb begin
        rx_ctrl_nxt = rx_ctrl_r;
        tx_ctrl_nxt = tx_ctrl_r;
        g1_val_nxt = g1_val_r;
        rdata_nxt = rdata_r;
        if (reg_wr) begin
            case (reg_sel(reg_addr))
                3'h1: rx_ctrl_nxt = reg_wdata & s3g_pkg::RX_CTRL_WMASK;
                3'h2: tx_ctrl_nxt = reg_wdata & s3g_pkg::TX_CTRL_WMASK;
                3'h4: g1_val_nxt = reg_wdata;
                default: g1_val_nxt = g1_val_r;
            endcase
        end
        if (reg_rd) begin
            case (reg_sel(reg_addr))
                3'h1: rdata_nxt = rx_ctrl_r;
                3'h2: rdata_nxt = tx_ctrl_r;
                3'h4: rdata_nxt = g1_val_r;
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    // Register file storage.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_ctrl_r <= s3g_pkg::RX_CTRL_RST;
            tx_ctrl_r <= s3g_pkg::TX_CTRL_RST;
            g1_val_r <= s3g_pkg::G1_VAL_RST;
            rdata_r <= 8'h00;
        end else begin
            rx_ctrl_r <= rx_ctrl_nxt;
            tx_ctrl_r <= tx_ctrl_nxt;
            g1_val_r <= g1_val_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // ------------------------------------------------------------
    // Overhead clock divider and serial input synchroniser
    // ------------------------------------------------------------
    assign rise_now = (div_r == 8'(OVH_HALF - 1)) && !ovh_clk_r;
    assign fall_now = (div_r == 8'(OVH_HALF - 1)) && ovh_clk_r;

    // clock source
    // The overhead clock toggles every OVH_HALF system clocks.
    always_comb begin
        div_nxt = div_r + 8'h01;
        ovh_clk_nxt = ovh_clk_r;
        if (div_r == 8'(OVH_HALF - 1)) begin
            div_nxt = 8'h00;
            ovh_clk_nxt = !ovh_clk_r;
        end
    end

    // Divider storage and the two-stage synchroniser on the serial pin.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_r <= 8'h00;
            ovh_clk_r <= 1'b0;
            sin_s1_r <= 1'b0;
            sin_s2_r <= 1'b0;
        end else begin
            div_r <= div_nxt;
            ovh_clk_r <= ovh_clk_nxt;
            sin_s1_r <= ovh.overhead_serial_in;
            sin_s2_r <= sin_s1_r;
        end
    end

    // ------------------------------------------------------------
    // Serial overhead window sequencer
    // ------------------------------------------------------------
    // Marks change on the falling overhead edge so the far end sees them settled
    // at the rising edge. The insert request pin is ignored: port mode alone selects.
    always_comb begin
        st_nxt = st_r;
        pend_nxt = pend_r;
        frame_nxt = frame_r;
        valid_nxt = valid_r;
        slot_nxt = slot_r;
        shift_nxt = shift_r;
        port_rdi_nxt = port_rdi_r;
        case (st_r)
            s3g_pkg::DS_IDLE: begin
                if (fall_now && pend_r) begin
                    st_nxt = s3g_pkg::DS_WINDOW;
                    pend_nxt = 1'b0;
                    frame_nxt = 1'b1;
                    valid_nxt = 1'b1;
                    slot_nxt = 8'h00;
                end
            end
            s3g_pkg::DS_WINDOW: begin
                if (rise_now) begin
                    slot_nxt = slot_r + 8'h01;
                    if (slot_r >= 8'(s3g_pkg::FIRST_LATCH) &&
                        slot_r <= 8'(s3g_pkg::LAST_LATCH)) begin
                        shift_nxt = {shift_r[1:0], sin_s2_r};
                    end
                    if (slot_r == 8'(s3g_pkg::LAST_LATCH)) begin
                        port_rdi_nxt = {shift_r[1:0], sin_s2_r};
                    end
                end
                if (fall_now) begin
                    frame_nxt = 1'b0;
                    if (slot_r >= 8'(s3g_pkg::POH_WINDOW_PERIODS)) begin
                        valid_nxt = 1'b0;
                        st_nxt = s3g_pkg::DS_IDLE;
                    end
                end
            end
            default: st_nxt = s3g_pkg::DS_IDLE;
        endcase
        // A new SPE start wins over the clear of the pending flag.
        if (spe_start) begin
            pend_nxt = 1'b1;
        end
    end

    // Sequencer storage.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= s3g_pkg::DS_IDLE;
            pend_r <= 1'b0;
            frame_r <= 1'b0;
            valid_r <= 1'b0;
            slot_r <= 8'h00;
            shift_r <= 3'h0;
            port_rdi_r <= 3'h0;
        end else begin
            st_r <= st_nxt;
            pend_r <= pend_nxt;
            frame_r <= frame_nxt;
            valid_r <= valid_nxt;
            slot_r <= slot_nxt;
            shift_r <= shift_nxt;
            port_rdi_r <= port_rdi_nxt;
        end
    end

    // ------------------------------------------------------------
    // G1 field assembly
    // ------------------------------------------------------------
    assign rdi_src = tx_ctrl_r[s3g_pkg::RDI_SRC_LSB +: 2];
    assign rei_src = tx_ctrl_r[s3g_pkg::REI_SRC_LSB +: 2];

    // Selects the remote defect and remote error codes from their sources.
    always_comb begin
        case (rdi_src)
            s3g_pkg::SRC_SOFT: rdi_out = g1_val_r[s3g_pkg::G1_RDI_LSB +: 3];
            s3g_pkg::SRC_PORT: rdi_out = port_rdi_r;
            default: rdi_out = 3'h0;
        endcase
        if (rei_src == s3g_pkg::SRC_SOFT) begin
            rei_out = g1_val_r[s3g_pkg::G1_REI_LSB +: 4];
        end else begin
            rei_out = rei_auto_r;
        end
    end

    // Captures receive-side B3 results and builds one G1 byte per outbound SPE.
    always_comb begin
        rei_auto_nxt = rei_auto_r;
        if (b3_update) begin
            if (rx_ctrl_r[s3g_pkg::B3_TYPE_BIT]) begin
                rei_auto_nxt = {3'h0, b3_err_seen};
            end else if (b3_err_count > s3g_pkg::REI_MAX) begin
                rei_auto_nxt = s3g_pkg::REI_MAX;
            end else begin
                rei_auto_nxt = b3_err_count;
            end
        end
        g1_valid_nxt = spe_start;
        g1_byte_nxt = g1_byte_r;
        if (spe_start) begin
            g1_byte_nxt = {rei_out, rdi_out, g1_spare};
        end
    end

    // G1 assembly storage.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rei_auto_r <= 4'h0;
            g1_byte_r <= 8'h00;
            g1_valid_r <= 1'b0;
        end else begin
            rei_auto_r <= rei_auto_nxt;
            g1_byte_r <= g1_byte_nxt;
            g1_valid_r <= g1_valid_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign ovh.overhead_serial_clock = ovh_clk_r;
    assign ovh.overhead_window_valid = valid_r;
    assign ovh.overhead_frame_mark = frame_r;
    assign reg_rdata = rdata_r;
    assign g1_byte = g1_byte_r;
    assign g1_valid = g1_valid_r;
endmodule : s3g_dev_end

/* File: core/s3g_host_end.sv */
// External inserter end: code FIFO and serial overhead driver.
`timescale 1ns/10ps
module s3g_fifo #(
    parameter int WIDTH = 3,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0] cnt_r, cnt_nxt;
    logic push, pop;

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Pointer and occupancy update; full and empty derive from the count.
    always_comb begin
        wp_nxt = push ? wp_r + AW'(1) : wp_r;
        rp_nxt = pop ? rp_r + AW'(1) : rp_r;
        cnt_nxt = cnt_r + (AW + 1)'(push) - (AW + 1)'(pop);
    end

    // FIFO storage.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // Data array, written only on an accepted push.
    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wp_r] <= in_data;
        end
    end

    assign in_ready = cnt_r != (AW + 1)'(DEPTH);
    assign out_valid = cnt_r != '0;
    assign out_data = mem_r[rp_r];
endmodule : s3g_fifo

module s3g_host_end #(
    parameter int FIFO_DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    s3g_ovh_if.host ovh,
    input wire logic rdi_valid,
    output logic rdi_ready,
    input wire logic [2:0] rdi_code,
    output logic rdi_sent
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [2:0] sync1_r, sync2_r;
    logic clk_prev_r;
    logic rise, fall;
    s3g_pkg::s3g_host_state_type st_r, st_nxt;
    logic [7:0] wait_r, wait_nxt;
    logic [1:0] idx_r, idx_nxt;
    logic [2:0] code_r, code_nxt;
    logic sout_r, sout_nxt;
    logic ins_r, ins_nxt;
    logic sent_r, sent_nxt;
    logic pop;
    logic fifo_valid;
    logic [2:0] fifo_data;

    // Codes queue here; the sequencer drains one per frame, so the FIFO can fill.
    s3g_fifo #(.WIDTH(3), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(rdi_valid),
        .in_ready(rdi_ready),
        .in_data(rdi_code),
        .out_valid(fifo_valid),
        .out_ready(pop),
        .out_data(fifo_data)
    );

    // ------------------------------------------------------------
    // Pin synchronisers and overhead clock edge detection
    // ------------------------------------------------------------
    // sample marks
    // Bit 0 clock, bit 1 window valid, bit 2 frame mark; all pass two flops.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_r <= 3'h0;
            sync2_r <= 3'h0;
            clk_prev_r <= 1'b0;
        end else begin
            sync1_r <= {ovh.overhead_frame_mark, ovh.overhead_window_valid,
                        ovh.overhead_serial_clock};
            sync2_r <= sync1_r;
            clk_prev_r <= sync2_r[0];
        end
    end
    assign rise = sync2_r[0] && !clk_prev_r;
    assign fall = !sync2_r[0] && clk_prev_r;

    // ------------------------------------------------------------
    // Insertion sequencer
    // ------------------------------------------------------------
    assign pop = (st_r == s3g_pkg::HS_SAMPLE) && rise && sync2_r[1] && sync2_r[2];

    // Waits out the slot, then shifts the code out MSB first on falling edges.
    always_comb begin
        st_nxt = st_r;
        wait_nxt = wait_r;
        idx_nxt = idx_r;
        code_nxt = code_r;
        sout_nxt = sout_r;
        ins_nxt = ins_r;
        sent_nxt = 1'b0;
        case (st_r)
            s3g_pkg::HS_SAMPLE: begin
                if (fall) begin
                    ins_nxt = 1'b0;
                end
                if (pop) begin
                    // An empty queue resends the previous code.
                    code_nxt = fifo_valid ? fifo_data : code_r;
                    wait_nxt = 8'h00;
                    st_nxt = s3g_pkg::HS_WAIT;
                end
            end
            s3g_pkg::HS_WAIT: begin
                if (rise) begin
                    wait_nxt = wait_r + 8'h01;
                    if (wait_r == 8'(s3g_pkg::OVH_WAIT_PERIODS - 1)) begin
                        st_nxt = s3g_pkg::HS_SHIFT;
                        idx_nxt = 2'h0;
                    end
                end
            end
            s3g_pkg::HS_SHIFT: begin
                if (fall) begin
                    sout_nxt = code_r[2'h2 - idx_r];
                    ins_nxt = 1'b1;
                    idx_nxt = idx_r + 2'h1;
                    if (idx_r == 2'(s3g_pkg::RDI_BIT_COUNT - 1)) begin
                        st_nxt = s3g_pkg::HS_SAMPLE;
                        sent_nxt = 1'b1;
                    end
                end
            end
            default: st_nxt = s3g_pkg::HS_SAMPLE;
        endcase
    end

    // Sequencer storage.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= s3g_pkg::HS_SAMPLE;
            wait_r <= 8'h00;
            idx_r <= 2'h0;
            code_r <= 3'h0;
            sout_r <= 1'b0;
            ins_r <= 1'b0;
            sent_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            wait_r <= wait_nxt;
            idx_r <= idx_nxt;
            code_r <= code_nxt;
            sout_r <= sout_nxt;
            ins_r <= ins_nxt;
            sent_r <= sent_nxt;
        end
    end

    assign ovh.overhead_serial_in = sout_r;
    assign ovh.overhead_insert_request = ins_r;
    assign rdi_sent = sent_r;
endmodule : s3g_host_end

/* File: testbench/s3g_monitor.sv */
// Concurrent checks on the serial overhead port between both ends.
`timescale 1ns/10ps
module s3g_monitor (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic overhead_serial_clock,
    input wire logic overhead_window_valid,
    input wire logic overhead_frame_mark,
    input wire logic overhead_serial_in,
    input wire logic overhead_insert_request
);
    logic sclk_d_r;
    logic sclk_d_nxt;
    logic [6:0] slot_r;
    logic [6:0] slot_nxt;

    // Counts overhead clock rises since the rise that saw the frame mark.
    always_comb begin
        sclk_d_nxt = overhead_serial_clock;
        slot_nxt = slot_r;
        if (overhead_serial_clock && !sclk_d_r) begin
            if (overhead_frame_mark) begin
                slot_nxt = 7'h00;
            end else if (slot_r != 7'h7f) begin
                slot_nxt = slot_r + 7'h01;
            end
        end
    end

    // Registers the edge detector and the slot count.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_d_r <= 1'b0;
            slot_r <= 7'h7f;
        end else begin
            sclk_d_r <= sclk_d_nxt;
            slot_r <= slot_nxt;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_frame_in_window: assert property (
        overhead_frame_mark |-> overhead_window_valid) else $error("frame mark outside window");
    chk_frame_opens_window: assert property (
        $rose(overhead_frame_mark) |-> $rose(overhead_window_valid))
        else $error("frame mark not at window start");
    chk_clock_high_half: assert property (
        $rose(overhead_serial_clock) |-> overhead_serial_clock[*8] ##1 !overhead_serial_clock)
        else $error("overhead clock high phase wrong");
    chk_clock_low_half: assert property (
        $fell(overhead_serial_clock) |-> !overhead_serial_clock[*8])
        else $error("overhead clock low phase short");
    chk_frame_one_period: assert property (
        $rose(overhead_frame_mark) |-> overhead_frame_mark[*8] ##1 overhead_frame_mark[*8]
        ##1 !overhead_frame_mark) else $error("frame mark not one period");
    chk_serial_low_phase: assert property (
        $changed(overhead_serial_in) |-> !overhead_serial_clock)
        else $error("serial bit changed while clock high");
    chk_serial_slot_time: assert property (
        $changed(overhead_serial_in) |-> (slot_r >= 7'h19 && slot_r <= 7'h1b))
        else $error("serial bit driven outside its slots");
    chk_request_at_first: assert property (
        $rose(overhead_insert_request) |-> slot_r == 7'h19)
        else $error("insert request raised outside first bit slot");
    chk_serial_in_window: assert property (
        $changed(overhead_serial_in) |-> overhead_window_valid)
        else $error("serial bit driven outside window");
endmodule : s3g_monitor

/* File: testbench/s3g_tb_top.sv */
// Self-checking bench joining the framer end and the inserter end.
`timescale 1ns/10ps
module s3g_tb_top;
    logic clk;
    logic rst_n;
    logic [15:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, g1_byte, g1v, e;
    logic reg_wr, reg_rd, spe_start, g1_spare, b3_update, b3_err_seen, typ;
    logic g1_valid, rdi_valid, rdi_ready, rdi_sent;
    logic [3:0] b3_err_count;
    logic [2:0] rdi_code;
    logic [1:0] rs, es;
    logic [2:0] codes [16];
    int mismatches, comparisons, seed, i, sent;

    s3g_ovh_if s3g_ovh_if_i();
    s3g_dev_end #(.OVH_HALF(8)) s3g_dev_end_i (.clk(clk), .rst_n(rst_n), .ovh(s3g_ovh_if_i),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .spe_start(spe_start), .g1_spare(g1_spare),
        .b3_update(b3_update), .b3_err_count(b3_err_count), .b3_err_seen(b3_err_seen),
        .g1_byte(g1_byte), .g1_valid(g1_valid));
    s3g_host_end #(.FIFO_DEPTH(16)) s3g_host_end_i (.clk(clk), .rst_n(rst_n),
        .ovh(s3g_ovh_if_i), .rdi_valid(rdi_valid), .rdi_ready(rdi_ready),
        .rdi_code(rdi_code), .rdi_sent(rdi_sent));
    s3g_monitor s3g_monitor_i (.clk(clk), .rst_n(rst_n),
        .overhead_serial_clock(s3g_ovh_if_i.overhead_serial_clock),
        .overhead_window_valid(s3g_ovh_if_i.overhead_window_valid),
        .overhead_frame_mark(s3g_ovh_if_i.overhead_frame_mark),
        .overhead_serial_in(s3g_ovh_if_i.overhead_serial_in),
        .overhead_insert_request(s3g_ovh_if_i.overhead_insert_request));

    // Expected remote error field from the receive results.
    function automatic logic [3:0] rei_exp(input logic t, input logic [3:0] c, input logic s);
        rei_exp = t ? {3'h0, s} : (c > s3g_pkg::REI_MAX) ? s3g_pkg::REI_MAX : c;
    endfunction : rei_exp

    // Counts one comparison and reports a mismatch.
    task automatic chk(input string n, input logic [7:0] x, input logic [7:0] g);
        comparisons++;
        if (g !== x) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", n, x, g);
        end
    endtask : chk

    // Prints the counts and the verdict, then ends the run.
    task automatic conclude;
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : conclude

    // One register write strobe.
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk) reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk) reg_wr = 1'b0;
    endtask : wr

    // One register read, compared a cycle after the strobe.
    task automatic rd(input logic [15:0] a, input logic [7:0] x);
        @(negedge clk) reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk) reg_rd = 1'b0;
        chk("reg_rdata", x, reg_rdata);
    endtask : rd

    // Starts one SPE, checks its G1 byte and waits out the overhead window.
    task automatic frame(input logic [7:0] x);
        @(negedge clk) spe_start = 1'b1;
        @(negedge clk) spe_start = 1'b0;
        chk("g1_valid", 8'h01, {7'h00, g1_valid});
        chk("g1_byte", x, g1_byte);
        repeat (1300) @(negedge clk);
    endtask : frame

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial begin
        repeat (40000) @(posedge clk);
        mismatches++;
        conclude();
    end

    // Counts the codes the inserter reports as sent, one per overhead window.
    always @(negedge clk) begin
        if (rdi_sent) begin
            sent++;
        end
    end

    initial begin
        {rst_n, reg_addr, reg_wdata, reg_wr, reg_rd, spe_start, g1_spare} = '0;
        {b3_update, b3_err_seen, b3_err_count, rdi_valid, rdi_code} = '0;
        seed = 32'h1a23;
        repeat (4) @(posedge clk);
        @(negedge clk) rst_n = 1'b1;
        rd(s3g_pkg::RX_CTRL_ADDR, s3g_pkg::RX_CTRL_RST);
        rd(s3g_pkg::TX_CTRL_ADDR, s3g_pkg::TX_CTRL_RST);
        rd(s3g_pkg::G1_VAL_ADDR, s3g_pkg::G1_VAL_RST);
        wr(s3g_pkg::RX_CTRL_ADDR, 8'hff);
        rd(s3g_pkg::RX_CTRL_ADDR, s3g_pkg::RX_CTRL_WMASK);
        wr(s3g_pkg::TX_CTRL_ADDR, 8'hff);
        rd(s3g_pkg::TX_CTRL_ADDR, s3g_pkg::TX_CTRL_WMASK);
        wr(16'h1184, 8'hff);
        rd(16'h1184, 8'h00);
        // Random source codes for both fields; corners 0, 8 and a clamped 15 first.
        for (i = 0; i < 6; i++) begin
            g1v = 8'($random(seed));
            typ = (i < 2) ? 1'b0 : 1'($random(seed));
            rs = (i < 2) ? s3g_pkg::SRC_SOFT : 2'($random(seed));
            es = (i < 2) ? s3g_pkg::SRC_AUTO : 2'($random(seed));
            b3_err_count = (i < 2) ? 4'(i * 8) : (i == 2) ? 4'hf : 4'($random(seed));
            b3_err_seen = 1'($random(seed));
            g1_spare = 1'($random(seed));
            wr(s3g_pkg::RX_CTRL_ADDR, {7'h00, typ});
            wr(s3g_pkg::TX_CTRL_ADDR, {1'b0, es, rs, 3'h0});
            wr(s3g_pkg::G1_VAL_ADDR, g1v);
            @(negedge clk) b3_update = 1'b1;
            @(negedge clk) b3_update = 1'b0;
            e = {rei_exp(typ, b3_err_count, b3_err_seen), 3'h0, g1_spare};
            e[3:1] = (rs == s3g_pkg::SRC_SOFT) ? g1v[3:1] : 3'h0;
            e[7:4] = (es == s3g_pkg::SRC_SOFT) ? g1v[7:4] : e[7:4];
            frame(e);
        end
        wr(s3g_pkg::TX_CTRL_ADDR, {1'b0, s3g_pkg::SRC_AUTO, s3g_pkg::SRC_PORT, 3'h0});
        // Fill the code buffer until it refuses, with one refused push.
        for (i = 0; i < 16; i++) begin
            codes[i] = 3'($random(seed));
            @(negedge clk) chk("rdi_ready", 8'h01, {7'h00, rdi_ready});
            rdi_valid = 1'b1;
            rdi_code = codes[i];
        end
        @(negedge clk) chk("rdi_ready", 8'h00, {7'h00, rdi_ready});
        rdi_code = ~codes[15];
        @(negedge clk) rdi_valid = 1'b0;
        // Serial-port codes appear one SPE later; an empty buffer repeats the last code.
        for (i = 0; i < 18; i++) begin
            e = {rei_exp(typ, b3_err_count, b3_err_seen), 3'h0, g1_spare};
            e[3:1] = (i == 0) ? 3'h0 : codes[(i > 16) ? 15 : i - 1];
            frame(e);
        end
        chk("rdi_sent", 8'h18, 8'(sent));
        conclude();
    end
endmodule : s3g_tb_top
